// [design/radio_ctrl_regs.vh]
`ifndef RADIO_CTRL_REGS_VH
`define RADIO_CTRL_REGS_VH
// serial word layout
`define WORD_BITS 16
`define WORD_MSB 15
`define ADDR_HI 15
`define ADDR_LO 14
`define DATA_MSB 13
`define REG_COUNT 4
`define BIT_COUNT_W 5
// power-control bit lives in register 0, bit 7
`define PWR_REG_IDX 2'h0
`define PWR_BIT_POS 7
// control register reset value
`define REG_RESET 14'h0000
// amplifier early turn-off lead, nanoseconds, and clock period
`define AMP_LEAD_NS 5000
`define CLK_PERIOD_NS 5
// lead in clock cycles: 5000 ns at 5 ns a cycle, sized to the lead counter
`define AMP_LEAD_CYC 11'd1000
`define AMP_CNT_W 11
`endif

// [design/sync2.v]
// ==========================================================
// two-flop synchroniser for a single pin
module sync2 (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire d_i,
  output wire q_o
);
  reg meta;
  reg stable;
  // first flop feeds only the second
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      stable <= 1'b0;
    end else if (ce_i) begin
      meta <= d_i;
      stable <= meta;
    end
  end
  assign q_o = stable;
endmodule // sync2

// [design/radio_serial_ctrl.v]
// How it works
// [RL1] enable low: sample data at clock rise
// [RL2] enable high: serial clock and data ignored
// [RL3] enable rising edge commits word to register
// [RL4] sixteen-bit words with two-bit register address
// [RL5] msb first, address in top bits
// [RL6] amplifier on with rf, off 5us early
// [RL7] interlock kills amplifier when synth unlocked
// [RL8] open-drain output low when power bit zero
// [RL9] power output updates on receive-select fall
// [RL10] power enable low means standby
// [RL11] receive select high receive, low transmit
`include "radio_ctrl_regs.vh"
module radio_serial_ctrl (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire ser_clk_i,
  input wire ser_data_i,
  input wire ser_en_i,
  input wire transceiver_power_enable_i,
  input wire receive_select_i,
  input wire tx_rf_present_i,
  input wire tx_rf_end_warn_i,
  input wire synth_locked_i,
  input wire interlock_sel_i,
  input wire tpc_mode_i,
  output reg [`DATA_MSB:0] ctrl_reg0_o,
  output reg [`DATA_MSB:0] ctrl_reg1_o,
  output reg [`DATA_MSB:0] ctrl_reg2_o,
  output reg [`DATA_MSB:0] ctrl_reg3_o,
  output reg word_commit_o,
  output reg standby_o,
  output reg rx_path_on_o,
  output reg tx_path_on_o,
  output reg amplifier_enable_out_o,
  output wire multi_function_out_o,
  output wire multi_function_out_oe_o
);
  // ==========================================================
  // pin synchronisers
  wire [5:0] raw_pins;
  wire [5:0] sync_pins;
  // enable and receive-select idle high: carried inverted so the flops' reset
  // level matches the idle pin and no false edge follows reset
  assign raw_pins = {ser_clk_i, ser_data_i, ~ser_en_i, transceiver_power_enable_i,
    ~receive_select_i, synth_locked_i};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      sync2 u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .d_i(raw_pins[g]),
        .q_o(sync_pins[g])
      );
    end
  endgenerate
  wire s_clk = sync_pins[5];
  wire s_data = sync_pins[4];
  wire s_en = ~sync_pins[3];
  wire s_pwr = sync_pins[2];
  wire s_rx = ~sync_pins[1];
  wire s_lock = sync_pins[0];

  // ==========================================================
  // edge history, taken from synchronised copies only
  reg clk_d;
  reg en_d;
  reg rx_d;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_d <= 1'b0;
      en_d <= 1'b1;
      rx_d <= 1'b1;
    end else if (ce_i) begin
      clk_d <= s_clk;
      en_d <= s_en;
      rx_d <= s_rx;
    end
  end
  // data and clock share the same synchroniser depth, so data is read as is
  wire clk_rise = s_clk & ~clk_d;
  wire en_rise = s_en & ~en_d;
  wire rx_fall = ~s_rx & rx_d;

  // ==========================================================
  // shifter: only runs while enable is low
  reg [`WORD_MSB:0] shift;
  reg [`BIT_COUNT_W-1:0] bit_cnt;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift <= {`WORD_BITS{1'b0}};
      bit_cnt <= {`BIT_COUNT_W{1'b0}};
    end else if (ce_i) begin
      if (s_en) begin
        bit_cnt <= {`BIT_COUNT_W{1'b0}}; // see [RL2]
      end else if (clk_rise) begin
        shift <= {shift[`WORD_MSB-1:0], s_data}; // see [RL1] see [RL5]
        if (bit_cnt != `WORD_BITS)
          bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // commit on enable rise; last bit shifted is the lsb
  wire [1:0] waddr = shift[`ADDR_HI:`ADDR_LO]; // see [RL4]
  function sel;
    input [1:0] a;
    input [1:0] idx;
    begin
      sel = (a == idx);
    end
  endfunction
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg0_o <= `REG_RESET;
      ctrl_reg1_o <= `REG_RESET;
      ctrl_reg2_o <= `REG_RESET;
      ctrl_reg3_o <= `REG_RESET;
      word_commit_o <= 1'b0;
    end else if (ce_i) begin
      word_commit_o <= en_rise;
      if (en_rise) begin
        // short words still commit; the host is expected to send 16 bits
        if (sel(waddr, 2'h0))
          ctrl_reg0_o <= shift[`DATA_MSB:0]; // see [RL3]
        if (sel(waddr, 2'h1))
          ctrl_reg1_o <= shift[`DATA_MSB:0]; // see [RL3]
        if (sel(waddr, 2'h2))
          ctrl_reg2_o <= shift[`DATA_MSB:0]; // see [RL3]
        if (sel(waddr, 2'h3))
          ctrl_reg3_o <= shift[`DATA_MSB:0]; // see [RL3]
      end
    end
  end

  // ==========================================================
  // power-step bit: held until receive-select falls
  reg tx_power_step_bit;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_power_step_bit <= 1'b0;
    end else if (ce_i) begin
      // the register bit itself is the pending value until the fall
      if (rx_fall)
        tx_power_step_bit <= ctrl_reg0_o[`PWR_BIT_POS]; // see [RL9]
    end
  end
  // open drain: drive low only, release means oe low
  assign multi_function_out_o = 1'b0;
  assign multi_function_out_oe_o = tpc_mode_i & ~tx_power_step_bit & s_pwr; // see [RL8]

  // ==========================================================
  // mode pins
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_o <= 1'b1;
      rx_path_on_o <= 1'b0;
      tx_path_on_o <= 1'b0;
    end else if (ce_i) begin
      standby_o <= ~s_pwr; // see [RL10]
      rx_path_on_o <= s_pwr & s_rx; // see [RL11]
      tx_path_on_o <= s_pwr & ~s_rx; // see [RL11]
    end
  end

  // ==========================================================
  // amplifier enable: on with rf present, drop when warned 5us ahead
  // the warning input marks the start of the lead; a counter then holds
  // the output low for the full lead so rf can be removed safely
  localparam AMP_IDLE = 3'b001;
  localparam AMP_ON = 3'b010;
  localparam AMP_LEAD = 3'b100;
  reg [2:0] amp_state;
  reg [`AMP_CNT_W-1:0] amp_cnt;
  wire amp_block = (interlock_sel_i & ~s_lock) | ~s_pwr | s_rx;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      amp_state <= AMP_IDLE;
      amp_cnt <= {`AMP_CNT_W{1'b0}};
      amplifier_enable_out_o <= 1'b0;
    end else if (ce_i) begin
      case (amp_state)
        AMP_IDLE: begin
          if (tx_rf_present_i && !tx_rf_end_warn_i)
            amp_state <= AMP_ON; // see [RL6]
        end
        AMP_ON: begin
          if (tx_rf_end_warn_i) begin
            amp_state <= AMP_LEAD; // see [RL6]
            amp_cnt <= `AMP_LEAD_CYC;
          end else if (!tx_rf_present_i) begin
            amp_state <= AMP_IDLE;
          end
        end
        AMP_LEAD: begin
          if (amp_cnt != {`AMP_CNT_W{1'b0}})
            amp_cnt <= amp_cnt - 1'b1;
          else if (!tx_rf_present_i)
            amp_state <= AMP_IDLE;
        end
        default: amp_state <= AMP_IDLE;
      endcase
      amplifier_enable_out_o <= (amp_state == AMP_ON) && !tx_rf_end_warn_i
        && !amp_block; // see [RL7]
    end
  end
endmodule // radio_serial_ctrl

// [tb/radio_serial_ctrl_props.sv]
// =====
// checker
module radio_serial_ctrl_props (
  input logic sys_clk_i,
  input logic nrst_i,
  input logic ser_en_i,
  input logic transceiver_power_enable_i,
  input logic receive_select_i,
  input logic tx_rf_present_i,
  input logic tx_rf_end_warn_i,
  input logic synth_locked_i,
  input logic interlock_sel_i,
  input logic tpc_mode_i,
  input logic [13:0] ctrl_reg0_o,
  input logic word_commit_o,
  input logic standby_o,
  input logic rx_path_on_o,
  input logic tx_path_on_o,
  input logic amplifier_enable_out_o,
  input logic multi_function_out_o,
  input logic multi_function_out_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // pin levels need time to cross the synchroniser
  sequence unlocked_s;
    (interlock_sel_i && !synth_locked_i) [*5];
  endsequence
  sequence mode_held_s;
    (transceiver_power_enable_i && $stable(receive_select_i)) [*4];
  endsequence
  a_commit_after_rise: assert property ($rose(ser_en_i) |-> ##[2:6] word_commit_o)
    else $error("missing commit");
  a_idle_no_write: assert property (ser_en_i [*8] |=> $stable(ctrl_reg0_o))
    else $error("write while idle");
  a_standby_entry: assert property (!transceiver_power_enable_i [*4] |-> standby_o)
    else $error("no standby");
  a_path_follows_mode: assert property (mode_held_s |->
    rx_path_on_o == receive_select_i && tx_path_on_o != receive_select_i) else $error("bad path");
  a_amp_lead_off: assert property (tx_rf_end_warn_i |-> ##[1:2] !amplifier_enable_out_o)
    else $error("amp late off");
  a_amp_needs_rf: assert property ($rose(amplifier_enable_out_o) |-> $past(tx_rf_present_i))
    else $error("amp without rf");
  a_amp_interlock: assert property (unlocked_s |-> !amplifier_enable_out_o)
    else $error("amp while unlocked");
  a_tpc_open_drain: assert property (multi_function_out_oe_o |->
    tpc_mode_i && !multi_function_out_o) else $error("bad pull");
  a_tpc_on_fall: assert property ($changed(multi_function_out_oe_o) && $stable(tpc_mode_i)
    && $stable(standby_o) |-> !receive_select_i) else $error("pull moved early");
endmodule // radio_serial_ctrl_props

bind radio_serial_ctrl radio_serial_ctrl_props props (.sys_clk_i, .nrst_i, .ser_en_i,
  .transceiver_power_enable_i, .receive_select_i, .tx_rf_present_i, .tx_rf_end_warn_i,
  .synth_locked_i, .interlock_sel_i, .tpc_mode_i, .ctrl_reg0_o, .word_commit_o, .standby_o,
  .rx_path_on_o, .tx_path_on_o, .amplifier_enable_out_o, .multi_function_out_o,
  .multi_function_out_oe_o);

// [tb/serial_host_model.sv]
// =====
// host side of the three-wire bus
module serial_host_model (
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: deselected, clock parked low
  initial begin
    ser_clk_o = 0;
    ser_data_o = 0;
    ser_en_o = 1;
  end
  // one frame, 160 ns clock, data settled 40 ns before each rise
  task automatic send(input logic [15:0] w);
    ser_en_o = 0;
    for (int i = 15; i >= 0; i--) begin
      ser_data_o = w[i];
      #40 ser_clk_o = 1;
      #80 ser_clk_o = 0;
      #40;
    end
    ser_en_o = 1;
    ser_data_o = ~w[0]; // released line must not look held
  endtask
  // clock and data toggled while deselected
  task automatic noise();
    repeat (4) begin
      #80 ser_clk_o = 1;
      ser_data_o = ~ser_data_o;
      #80 ser_clk_o = 0;
    end
  endtask
endmodule // serial_host_model

// [tb/test_radio_serial_ctrl_and_mode_pins.sv]
// =====
// bench
module test_radio_serial_ctrl_and_mode_pins;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, nrst_i, transceiver_power_enable_i, receive_select_i, tx_rf_present_i;
  logic tx_rf_end_warn_i, synth_locked_i, interlock_sel_i, tpc_mode_i, held;
  wire ser_clk_i, ser_data_i, ser_en_i, word_commit_o, standby_o, rx_path_on_o, tx_path_on_o;
  wire amplifier_enable_out_o, multi_function_out_o, multi_function_out_oe_o;
  wire [13:0] ctrl_reg0_o, ctrl_reg1_o, ctrl_reg2_o, ctrl_reg3_o;
  logic [55:0] exp_regs;
  int failures, checked, seed;
  serial_host_model host (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i), .ser_en_o(ser_en_i));
  radio_serial_ctrl uut (.sys_clk_i, .nrst_i, .ce_i(1'b1), .ser_clk_i, .ser_data_i, .ser_en_i,
    .transceiver_power_enable_i, .receive_select_i, .tx_rf_present_i, .tx_rf_end_warn_i,
    .synth_locked_i, .interlock_sel_i, .tpc_mode_i, .ctrl_reg0_o, .ctrl_reg1_o, .ctrl_reg2_o,
    .ctrl_reg3_o, .word_commit_o, .standby_o, .rx_path_on_o, .tx_path_on_o,
    .amplifier_enable_out_o, .multi_function_out_o, .multi_function_out_oe_o);
  // register image after a word lands at its address
  function automatic logic [55:0] after_write(logic [55:0] r, logic [15:0] w);
    r[w[15:14] * 14 +: 14] = w[13:0];
    return r;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic put(input logic [15:0] w);
    int n;
    host.send(w);
    exp_regs = after_write(exp_regs, w);
    for (n = 0; n < 12 && word_commit_o !== 1'b1; n++) wt(1);
    check(word_commit_o, 1);
    check({ctrl_reg3_o, ctrl_reg2_o, ctrl_reg1_o, ctrl_reg0_o}, exp_regs);
    wt(40); // enable pulse width
  endtask
  initial begin
    sys_clk_i = 0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // watchdog: whole run is about 43 us
  initial begin
    #300us;
    failures++;
    test_done();
  end
  // main sequence
  initial begin
    {nrst_i, transceiver_power_enable_i, tx_rf_present_i, tx_rf_end_warn_i} = '0;
    {interlock_sel_i, tpc_mode_i, receive_select_i, synth_locked_i} = 4'h3;
    {failures, checked, seed, exp_regs} = {32'd0, 32'd0, 32'd10, 56'h0};
    wt(8);
    @(posedge sys_clk_i) nrst_i <= 1;
    transceiver_power_enable_i <= 1;
    wt(4);
    for (int i = 0; i < 4; i++) put({i[1:0], 14'h3FFF});
    repeat (8) put(16'($random(seed)));
    put(16'h0080);
    host.noise();
    wt(20);
    check({ctrl_reg3_o, ctrl_reg2_o, ctrl_reg1_o, ctrl_reg0_o}, exp_regs);
    @(posedge sys_clk_i) transceiver_power_enable_i <= 0;
    wt(6);
    check(standby_o, 1);
    @(posedge sys_clk_i) transceiver_power_enable_i <= 1;
    receive_select_i <= 0;
    held = exp_regs[7];
    wt(6);
    check({standby_o, rx_path_on_o, tx_path_on_o}, 3'h1);
    put(16'h0000);
    @(posedge sys_clk_i) tpc_mode_i <= 1;
    wt(6);
    check(multi_function_out_oe_o, !held);
    @(posedge sys_clk_i) receive_select_i <= 1;
    wt(6);
    check({rx_path_on_o, tx_path_on_o}, 2'h2);
    @(posedge sys_clk_i) receive_select_i <= 0;
    held = exp_regs[7];
    wt(6);
    check({multi_function_out_oe_o, multi_function_out_o}, {!held, 1'b0});
    put(16'h0080);
    check(multi_function_out_oe_o, !held);
    // interlock must be on, or an unlocked synthesizer would not block the amplifier
    @(posedge sys_clk_i) synth_locked_i <= 0;
    interlock_sel_i <= 1;
    tx_rf_present_i <= 1;
    wt(8);
    check(amplifier_enable_out_o, 0);
    @(posedge sys_clk_i) synth_locked_i <= 1;
    wt(6);
    check(amplifier_enable_out_o, 1);
    @(posedge sys_clk_i) tx_rf_end_warn_i <= 1;
    wt(2);
    check(amplifier_enable_out_o, 0);
    test_done();
  end
endmodule // test_radio_serial_ctrl_and_mode_pins
